// ### csc_regs.svh
// register map, reset values and timing counts of the crane speed select
//------------------------------------------------------------------------
// How it works
// [RULE1] any run input going active issues a run at 6 Hz in crane modes
// [RULE2] both run inputs off, or both on, ramps output frequency to zero
// [RULE3] two-step mode: accel input ramps toward upper limit, release holds
// [RULE4] three-step mode: step accel input ramps toward the upper limit
// [RULE5] three-step mode: hold input freezes speed, release returns to 6 Hz
// [RULE6] five-speed: preset n needs presets one to n-1 active as well
// [RULE7] two- and three-speed modes use only one or two preset inputs
// [RULE8] unipolar analog sets speed between lower and upper limits
// [RULE9] bipolar analog sets speed and direction between the limits
// [RULE10] both run inputs in a crane mode halt with a sequence alarm
// [RULE11] sequence alarm clears only once every discrete input is released
// [RULE12] brake release needs torque at threshold, 10.00 to 250.0 percent
// [RULE13] torque must reach threshold within proving time, 0.5 to 10.0 s
// [RULE14] torque is also compared during the stable countdown
// [RULE15] torque must stay at threshold for the stable time before release
// [RULE16] axis select: closed-loop hoist default, open-loop, main, bridge
// [RULE17] speed method defaults to two-step; standard is plain drive
// [RULE18] accelerating speed is clamped at the upper limit
//------------------------------------------------------------------------
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
// byte offsets
`define CSC_OFS_CTRL 6'h00
`define CSC_OFS_UPPER 6'h04
`define CSC_OFS_LOWER 6'h08
`define CSC_OFS_STEP 6'h0c
`define CSC_OFS_PRESET1 6'h10
`define CSC_OFS_PRESET4 6'h1c
`define CSC_OFS_THR 6'h20
`define CSC_OFS_PROVE 6'h24
`define CSC_OFS_STABLE 6'h28
`define CSC_OFS_STATUS 6'h2c
`define CSC_OFS_IRQ_ST 6'h30
`define CSC_OFS_IRQ_MASK 6'h34
// ctrl fields
`define CSC_CTRL_MODE_LSB 0
`define CSC_CTRL_AXIS_LSB 4
// status fields
`define CSC_ST_DIR_BIT 16
`define CSC_ST_ALARM_BIT 17
`define CSC_ST_OPEN_BIT 18
// interrupt bits
`define CSC_IRQ_ALARM 0
`define CSC_IRQ_OPEN 1
`define CSC_IRQ_FAULT 2
// frequencies in 0.01 Hz
`define CSC_FREQ_RUN 16'h0258
`define CSC_RST_UPPER 16'h1770
`define CSC_RST_LOWER 16'h0258
`define CSC_RST_STEP 16'h000a
`define CSC_RST_PRESET 16'h03e8
// torque in 0.01 percent
`define CSC_RST_THR 16'h2710
`define CSC_THR_MIN 16'h03e8
`define CSC_THR_MAX 16'h61a8
// proving time in 0.1 s, stable time in 0.01 s
`define CSC_RST_PROVE 8'h0a
`define CSC_PROVE_MIN 8'h05
`define CSC_PROVE_MAX 8'h64
`define CSC_RST_STABLE 8'h14
`define CSC_PROVE_MS 8'h64
`define CSC_STABLE_MS 8'h0a
// timing base
`define CSC_CLK_NS 5
`define CSC_TICK_NS 1000000
`endif

// ### csc_pkg.sv
// types of the crane speed select
package csc_pkg;
   typedef enum logic [2:0] {
      CSC_STD, CSC_STEP2, CSC_STEP3, CSC_SPD5,
      CSC_SPD2, CSC_SPD3, CSC_UNI, CSC_BIP
   } csc_mode_t;
   typedef enum logic [2:0] {
      CSC_CL_HOIST, CSC_OL_HOIST, CSC_MAIN_HOIST, CSC_BRIDGE, CSC_ROTATE
   } csc_axis_t;
   typedef enum logic [2:0] {
      B_SET, B_PROVE, B_STABLE, B_OPEN, B_FAULT
   } csc_brake_t;
   typedef struct packed {
      csc_mode_t mode;
      csc_axis_t axis;
      logic [15:0] upper;
      logic [15:0] lower;
      logic [15:0] step;
      logic [3:0][15:0] preset;
      logic [15:0] thr;
      logic [7:0] prove;
      logic [7:0] stable;
      logic [2:0] irq_st;
      logic [2:0] irq_mask;
      logic ack;
      logic [31:0] rdata;
      logic [31:0] presc;
      logic tick;
      logic [15:0] freq;
      logic rev_dir;
      logic alarm;
      csc_brake_t brake;
      logic [15:0] pcnt;
      logic [15:0] scnt;
   } csc_state_t;
endpackage : csc_pkg

// ### csc_sync.sv
// two-flop synchroniser for a group of pin levels
module csc_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   // one pair of flops per bit; only the second flop is read
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge core_clk_i)
      begin
         if (!rst_b_i)
         begin
            meta_reg[i] <= 1'b0;
            sync_o[i] <= 1'b0;
         end
         else
         begin
            meta_reg[i] <= async_i[i];
            sync_o[i] <= meta_reg[i];
         end
      end
   end
endmodule : csc_sync

// ### csc_speed_select.sv
// crane speed command select with brake proving and register slave
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`include "csc_regs.svh"
module csc_speed_select
   import csc_pkg::*;
#(
   parameter int TICK_CYCLES = `CSC_TICK_NS / `CSC_CLK_NS,
   parameter int ANA_W = 12
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // avalon-mm slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // pendant pins
   input wire logic fwd_run_i,
   input wire logic rev_run_i,
   input wire logic [5:0] aux_i,
   // analog converters and torque estimate, same clock
   input wire logic [ANA_W-1:0] unipolar_speed_input_i,
   input wire logic signed [ANA_W-1:0] bipolar_speed_i,
   input wire logic [15:0] torque_i,
   // drive side
   output logic [15:0] freq_cmd_o,
   output logic dir_rev_o,
   output logic run_cmd_o,
   output logic brake_release_o,
   output logic alarm_o,
   output logic irq_o
);
   //---------------------------------------------------------------------
   // checks and constants
   //---------------------------------------------------------------------
   if (TICK_CYCLES < 2 || ANA_W < 2 || ANA_W > 16)
   begin : g_bad
      $error("csc_speed_select: unsupported parameter values");
   end
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

   csc_state_t r, n;
   logic [7:0] pins;
   logic fwd, rev, run_one, both, any_in, proving_axis;
   logic accel_request_input, step_accel_input, step_hold_input;
   logic preset_speed_one;
   logic [15:0] prove_ms, stable_ms;

   //---------------------------------------------------------------------
   // pin synchronisers
   //---------------------------------------------------------------------
   csc_sync #(
      .WIDTH(8)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .async_i({aux_i, rev_run_i, fwd_run_i}),
      .sync_o(pins)
   );

   // decoded discrete inputs
   assign fwd = pins[0];
   assign rev = pins[1];
   assign accel_request_input = pins[2];
   assign preset_speed_one = pins[4];
   assign step_accel_input = pins[4];
   assign step_hold_input = pins[5];
   assign run_one = fwd ^ rev;
   assign both = fwd & rev;
   assign any_in = |pins;
   // only the closed-loop and main hoist axes prove torque before release
   assign proving_axis = (r.axis == CSC_CL_HOIST) ||
      (r.axis == CSC_MAIN_HOIST); // RULE16
   assign prove_ms = 16'(r.prove * `CSC_PROVE_MS);
   assign stable_ms = 16'(r.stable * `CSC_STABLE_MS);

   // byte-lane merge for 16-bit registers
   function automatic logic [15:0] csc_merge(input logic [15:0] old_v);
      logic [15:0] m;
      m = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      return (old_v & ~m) | (avs_writedata_i[15:0] & m);
   endfunction : csc_merge

   //---------------------------------------------------------------------
   // next state
   //---------------------------------------------------------------------
   always_comb
   begin
      logic [15:0] tgt;
      logic [15:0] span;
      logic [15:0] v;
      logic [ANA_W-1:0] mag;
      logic [2:0] lvl;
      logic [2:0] maxlvl;
      logic hold;
      logic wr;
      logic [2:0] ev;
      tgt = 16'h0000;
      span = r.upper - r.lower;
      v = 16'h0000;
      mag = '0;
      lvl = 3'h0;
      maxlvl = 3'h4;
      hold = 1'b0;
      wr = 1'b0;
      ev = 3'h0;
      n = r;

      // millisecond tick paces ramps and brake timing
      n.tick = (r.presc == TICK_LAST);
      n.presc = n.tick ? 32'h0 : r.presc + 32'h1;

      // one wait cycle per access, then the answer
      n.ack = (avs_read_i | avs_write_i) & ~r.ack;
      // a write lands only at the edge where waitrequest is seen low
      wr = avs_write_i & r.ack;
      if (avs_read_i && !r.ack)
      begin
         case (avs_address_i)
            `CSC_OFS_CTRL: n.rdata = {25'h0, r.axis, 1'b0, r.mode};
            `CSC_OFS_UPPER: n.rdata = {16'h0, r.upper};
            `CSC_OFS_LOWER: n.rdata = {16'h0, r.lower};
            `CSC_OFS_STEP: n.rdata = {16'h0, r.step};
            6'h10, 6'h14, 6'h18, `CSC_OFS_PRESET4:
               n.rdata = {16'h0, r.preset[avs_address_i[3:2]]};
            `CSC_OFS_THR: n.rdata = {16'h0, r.thr};
            `CSC_OFS_PROVE: n.rdata = {24'h0, r.prove};
            `CSC_OFS_STABLE: n.rdata = {24'h0, r.stable};
            `CSC_OFS_STATUS: n.rdata = {13'h0, r.brake == B_OPEN,
               r.alarm, r.rev_dir, r.freq};
            `CSC_OFS_IRQ_ST: n.rdata = {29'h0, r.irq_st};
            `CSC_OFS_IRQ_MASK: n.rdata = {29'h0, r.irq_mask};
            default: n.rdata = 32'h0;
         endcase
      end
      if (wr)
      begin
         case (avs_address_i)
            `CSC_OFS_CTRL:
            begin
               if (avs_byteenable_i[0])
               begin
                  n.mode = csc_mode_t'(avs_writedata_i[2:0]); // RULE17
                  if (avs_writedata_i[6:4] <= 3'h4)
                     n.axis = csc_axis_t'(avs_writedata_i[6:4]); // RULE16
               end
            end
            `CSC_OFS_UPPER: n.upper = csc_merge(r.upper);
            `CSC_OFS_LOWER: n.lower = csc_merge(r.lower);
            `CSC_OFS_STEP: n.step = csc_merge(r.step);
            6'h10, 6'h14, 6'h18, `CSC_OFS_PRESET4:
               n.preset[avs_address_i[3:2]] =
                  csc_merge(r.preset[avs_address_i[3:2]]);
            `CSC_OFS_THR:
            begin
               // out-of-range thresholds are clipped, not refused
               v = csc_merge(r.thr);
               if (v < `CSC_THR_MIN)
                  n.thr = `CSC_THR_MIN; // RULE12
               else if (v > `CSC_THR_MAX)
                  n.thr = `CSC_THR_MAX; // RULE12
               else
                  n.thr = v;
            end
            `CSC_OFS_PROVE:
            begin
               if (avs_byteenable_i[0])
               begin
                  if (avs_writedata_i[7:0] < `CSC_PROVE_MIN)
                     n.prove = `CSC_PROVE_MIN; // RULE13
                  else if (avs_writedata_i[7:0] > `CSC_PROVE_MAX)
                     n.prove = `CSC_PROVE_MAX; // RULE13
                  else
                     n.prove = avs_writedata_i[7:0];
               end
            end
            `CSC_OFS_STABLE:
               if (avs_byteenable_i[0])
                  n.stable = avs_writedata_i[7:0]; // RULE15
            `CSC_OFS_IRQ_MASK:
               if (avs_byteenable_i[0])
                  n.irq_mask = avs_writedata_i[2:0];
            default: ;
         endcase
      end

      // sequence alarm: raised on both runs outside standard mode, held until all released
      if (r.mode != CSC_STD && both && !r.alarm)
      begin
         n.alarm = 1'b1; // RULE10
         ev[`CSC_IRQ_ALARM] = 1'b1;
      end
      else if (r.alarm && !any_in)
         n.alarm = 1'b0; // RULE11

      // speed target per method
      case (r.mode)
         CSC_STEP2:
         begin
            // from standstill the run input alone asks for the run level
            tgt = accel_request_input ? r.upper :
               (r.freq == 16'h0) ? `CSC_FREQ_RUN : r.freq; // RULE3
            hold = !accel_request_input && r.freq != 16'h0; // RULE3
         end
         CSC_STEP3:
         begin
            if (step_hold_input)
               hold = 1'b1; // RULE5
            else if (step_accel_input)
               tgt = r.upper; // RULE4
            else
               tgt = `CSC_FREQ_RUN; // RULE5
         end
         CSC_SPD5, CSC_SPD2, CSC_SPD3:
         begin
            // the first gap in the preset chain caps the level
            maxlvl = (r.mode == CSC_SPD2) ? 3'h1 :
               (r.mode == CSC_SPD3) ? 3'h2 : 3'h4; // RULE7
            if (preset_speed_one)
            begin
               lvl = 3'h1; // RULE6
               if (pins[5])
               begin
                  lvl = 3'h2; // RULE6
                  if (pins[6])
                     lvl = pins[7] ? 3'h4 : 3'h3; // RULE6
               end
            end
            if (lvl > maxlvl)
               lvl = maxlvl; // RULE7
            tgt = (lvl == 3'h0) ? `CSC_FREQ_RUN :
               r.preset[2'(lvl - 3'h1)]; // RULE6
         end
         CSC_UNI:
            tgt = r.lower + 16'((32'(span) *
               32'(unipolar_speed_input_i)) >> ANA_W); // RULE8
         CSC_BIP:
         begin
            mag = bipolar_speed_i[ANA_W-1] ? ANA_W'(-bipolar_speed_i) :
               ANA_W'(bipolar_speed_i);
            tgt = r.lower + 16'((32'(span) * 32'(mag))
               >> (ANA_W - 1)); // RULE9
         end
         default:
            tgt = r.upper; // RULE17
      endcase
      if (tgt > r.upper)
         tgt = r.upper; // RULE18
      // no run, both runs or a halt ramp to zero
      if (!run_one || r.alarm || r.brake == B_FAULT)
      begin
         tgt = 16'h0; // RULE2
         hold = 1'b0;
      end
      // speed stays at the run level until the brake has let go
      else if (r.brake != B_OPEN && tgt > `CSC_FREQ_RUN)
      begin
         tgt = `CSC_FREQ_RUN;
         hold = 1'b0;
      end

      // frequency update: instant run level on start, ramp on tick
      if (run_one && !r.alarm && r.freq == 16'h0 && tgt != 16'h0)
      begin
         n.freq = `CSC_FREQ_RUN; // RULE1
         n.rev_dir = (r.mode == CSC_BIP) ?
            rev ^ bipolar_speed_i[ANA_W-1] : rev; // RULE9
      end
      else if (r.tick && !hold)
      begin
         if (r.freq < tgt)
            n.freq = (tgt - r.freq > r.step) ?
               r.freq + r.step : tgt; // RULE18
         else if (r.freq > tgt)
            n.freq = (r.freq - tgt > r.step) ?
               r.freq - r.step : tgt; // RULE2
      end

      // brake sequence
      case (r.brake)
         B_SET:
         begin
            n.pcnt = 16'h0;
            n.scnt = 16'h0;
            if (run_one && !r.alarm && r.freq != 16'h0)
               n.brake = proving_axis ? B_PROVE : B_OPEN;
            if (run_one && !r.alarm && r.freq != 16'h0 && !proving_axis)
               ev[`CSC_IRQ_OPEN] = 1'b1;
         end
         B_PROVE:
         begin
            if (torque_i >= r.thr)
            begin
               n.brake = B_STABLE; // RULE12
               n.scnt = 16'h0;
            end
            else if (r.pcnt >= prove_ms)
            begin
               n.brake = B_FAULT; // RULE13
               ev[`CSC_IRQ_FAULT] = 1'b1;
            end
            else if (r.tick)
               n.pcnt = r.pcnt + 16'h1; // RULE13
         end
         B_STABLE:
         begin
            // a dip restarts the stable count but not the proving window
            if (torque_i < r.thr)
               n.brake = B_PROVE; // RULE14
            else if (r.scnt >= stable_ms)
            begin
               n.brake = B_OPEN; // RULE15
               ev[`CSC_IRQ_OPEN] = 1'b1;
            end
            else if (r.tick)
               n.scnt = r.scnt + 16'h1; // RULE15
         end
         B_OPEN:
            if (r.freq == 16'h0)
               n.brake = B_SET;
         B_FAULT:
            if (!fwd && !rev)
               n.brake = B_SET;
         default:
            n.brake = B_SET;
      endcase
      if ((!run_one || r.alarm) && r.brake != B_OPEN &&
         r.brake != B_FAULT)
         n.brake = B_SET;
      if (r.brake == B_OPEN && r.alarm)
         n.brake = B_SET;

      // sticky events, set wins over a write-one clear
      if (wr && avs_address_i == `CSC_OFS_IRQ_ST && avs_byteenable_i[0])
         n.irq_st = r.irq_st & ~avs_writedata_i[2:0];
      n.irq_st = n.irq_st | ev;
   end

   //---------------------------------------------------------------------
   // state register
   //---------------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         r <= '0;
         r.mode <= CSC_STEP2; // RULE17
         r.axis <= CSC_CL_HOIST; // RULE16
         r.upper <= `CSC_RST_UPPER;
         r.lower <= `CSC_RST_LOWER;
         r.step <= `CSC_RST_STEP;
         r.preset <= {4{`CSC_RST_PRESET}};
         r.thr <= `CSC_RST_THR; // RULE12
         r.prove <= `CSC_RST_PROVE; // RULE13
         r.stable <= `CSC_RST_STABLE; // RULE15
         r.brake <= B_SET;
      end
      else
         r <= n;
   end

   // outputs
   assign avs_readdata_o = r.rdata;
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~r.ack;
   assign freq_cmd_o = r.freq;
   assign dir_rev_o = r.rev_dir;
   assign run_cmd_o = (r.freq != 16'h0);
   assign brake_release_o = (r.brake == B_OPEN);
   assign alarm_o = r.alarm;
   assign irq_o = |(r.irq_st & r.irq_mask);

   //---------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_done;
      !avs_waitrequest_o;
   endsequence
   property p_bus_answer;
      s_req |=> s_done;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus access not answered in one cycle");

   property p_both_no_rise;
      both |=> r.freq <= $past(r.freq);
   endproperty
   a_both_no_rise: assert property (p_both_no_rise) // RULE2
      else $error("frequency rose with both run inputs on");

   property p_alarm_set;
      (r.mode != CSC_STD) && both |=> r.alarm;
   endproperty
   a_alarm_set: assert property (p_alarm_set) // RULE10
      else $error("alarm missing on both run inputs");

   property p_alarm_keep;
      r.alarm && any_in |=> r.alarm;
   endproperty
   a_alarm_keep: assert property (p_alarm_keep) // RULE11
      else $error("alarm cleared while an input was active");

   property p_alarm_clear;
      r.alarm && !any_in |=> !r.alarm;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) // RULE11
      else $error("alarm held after all inputs released");

   property p_clamp;
      r.freq > $past(r.freq) |-> r.freq <= $past(r.upper);
   endproperty
   a_clamp: assert property (p_clamp) // RULE18
      else $error("frequency rose past the upper limit");

   property p_release_torque;
      $rose(brake_release_o) && $past(proving_axis) |->
         $past(r.brake) == B_STABLE && $past(torque_i) >= $past(r.thr);
   endproperty
   a_release_torque: assert property (p_release_torque) // RULE15
      else $error("brake released without stable torque");

   property p_prove_window;
      r.brake == B_PROVE |-> r.pcnt <= prove_ms;
   endproperty
   a_prove_window: assert property (p_prove_window) // RULE13
      else $error("proving count ran past its window");

   property p_start_run;
      run_one && !r.alarm && r.freq == 16'h0 && !$past(run_one) &&
         r.mode inside {CSC_STEP2, CSC_STEP3} |=>
         r.freq == `CSC_FREQ_RUN;
   endproperty
   a_start_run: assert property (p_start_run) // RULE1
      else $error("run start did not give the run frequency");

   property p_hold3;
      r.mode == CSC_STEP3 && step_hold_input && run_one && !r.alarm &&
         r.brake == B_OPEN && r.freq != 16'h0 |=>
         r.freq == $past(r.freq);
   endproperty
   a_hold3: assert property (p_hold3) // RULE5
      else $error("hold input did not freeze the frequency");
endmodule : csc_speed_select

// ### csc_hoist_model.sv
// hoist motor stand-in that builds torque while the drive runs
module csc_hoist_model (
   // clock
   input wire logic core_clk_i,
   // drive side
   input wire logic run_cmd_i,
   input wire logic [15:0] load_i,
   // torque estimate back to the drive
   output logic [15:0] torque_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // torque climbs in coarse steps so proving is never instant;
   // a low load keeps it under threshold to provoke a proving fault
   always_ff @(posedge core_clk_i)
   begin
      if (!run_cmd_i)
      begin
         torque_o <= 16'h0000;
      end
      else if (torque_o < load_i)
      begin
         torque_o <= torque_o + 16'h0100;
      end
   end
endmodule : csc_hoist_model

// ### tb.sv
// self-checking bench of the crane speed select
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   //------------------------------------------------------------
   // stimulus and observed signals
   //------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic fwd = 1'b0;
   logic rev = 1'b0;
   logic [5:0] aux = 6'h00;
   logic [15:0] load = 16'h0800;
   logic [11:0] ana = 12'h000;
   logic [31:0] rdat;
   logic waitreq, run, brel, alarm, irq, dir;
   logic [15:0] freq, torque;
   int fail_count = 0;
   int check_count = 0;
   logic [5:0] pm [5] = '{6'h04, 6'h0c, 6'h3c, 6'h2c, 6'h08};
   logic [15:0] pf [5] = '{16'h03e8, 16'h07d0, 16'h0a00, 16'h07d0, 16'h0258};
   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;
   // short tick so that times in ms stay affordable
   csc_speed_select #(.TICK_CYCLES(20)) uut (
      .core_clk_i(core_clk), .rst_b_i(rst_b), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hf),
      .avs_writedata_i(wdat), .avs_readdata_o(rdat),
      .avs_waitrequest_o(waitreq), .fwd_run_i(fwd), .rev_run_i(rev),
      .aux_i(aux), .unipolar_speed_input_i(ana),
      .bipolar_speed_i(ana), .torque_i(torque), .freq_cmd_o(freq),
      .dir_rev_o(dir), .run_cmd_o(run), .brake_release_o(brel),
      .alarm_o(alarm), .irq_o(irq));
   csc_hoist_model motor (.core_clk_i(core_clk), .run_cmd_i(run),
      .load_i(load), .torque_o(torque));
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask : chk
   // one access; the request stands until waitrequest is sampled low,
   // and an idle edge follows so strobes never toggle in one step
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      @(posedge core_clk);
      while (waitreq !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge core_clk);
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n == 50) fail_count++;
      @(posedge core_clk);
   endtask : bus
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd_chk
   task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, {16'h0000, d}, q);
   endtask : wr_reg
   // bounded wait: 0 watches frequency, 1 brake, 2 alarm
   task automatic wait_on(input int sel, input logic [15:0] exp);
      logic [15:0] v;
      for (int n = 0; n < 30000; n++)
      begin
         v = sel == 0 ? freq : sel == 1 ? {15'h0, brel} : {15'h0, alarm};
         if (v === exp) break;
         @(posedge core_clk);
      end
      chk({16'h0000, v}, {16'h0000, exp});
   endtask : wait_on
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run
   // watchdog sized well above the longest expected run
   initial
   begin
      repeat (90000) @(posedge core_clk);
      fail_count++;
      complete_run();
   end
   // main sequence
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rd_chk(6'h00, 32'h1);
      rd_chk(6'h20, 32'h2710);
      rd_chk(6'h24, 32'h0a);
      rd_chk(6'h28, 32'h14);
      rd_chk(6'h3c, 32'h0);
      $display("test reset values done");
      wr_reg(6'h04, 16'h0bb8);
      wr_reg(6'h0c, 16'h0064);
      wr_reg(6'h20, 16'h03e8);
      wr_reg(6'h34, 16'h0007);
      fwd <= 1'b1;
      wait_on(0, 16'h0258);
      repeat (2000) @(posedge core_clk);
      chk(brel, 32'h0);
      wait_on(1, 16'h0001);
      @(posedge core_clk);
      chk(irq, 32'h1);
      rd_chk(6'h30, 32'h2);
      wr_reg(6'h30, 16'h0002);
      @(posedge core_clk);
      chk(irq, 32'h0);
      aux <= 6'h01;
      wait_on(0, 16'h0bb8);
      aux <= 6'h00;
      repeat (400) @(posedge core_clk);
      chk(freq, 32'h0bb8);
      fwd <= 1'b0;
      wait_on(0, 16'h0000);
      $display("test two-step run done");
      // too little torque: proving must time out
      wr_reg(6'h24, 16'h0005);
      load <= 16'h0200;
      fwd <= 1'b1;
      repeat (12000) @(posedge core_clk);
      chk(brel, 32'h0);
      rd_chk(6'h30, 32'h4);
      fwd <= 1'b0;
      wait_on(0, 16'h0000);
      load <= 16'h0800;
      wr_reg(6'h30, 16'h0007);
      $display("test proving fault done");
      fwd <= 1'b1;
      rev <= 1'b1;
      wait_on(2, 16'h0001);
      chk(irq, 32'h1);
      wait_on(0, 16'h0000);
      rev <= 1'b0;
      repeat (50) @(posedge core_clk);
      chk(alarm, 32'h1);
      fwd <= 1'b0;
      wait_on(2, 16'h0000);
      wr_reg(6'h30, 16'h0007);
      $display("test sequence alarm done");
      // five-speed on the bridge axis, which releases at once
      wr_reg(6'h00, 16'h0033);
      wr_reg(6'h14, 16'h07d0);
      wr_reg(6'h1c, 16'h0a00);
      fwd <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         aux <= pm[i];
         wait_on(0, pf[i]);
      end
      aux <= 6'h0c;
      wr_reg(6'h00, 16'h0034);
      wait_on(0, 16'h03e8);
      aux <= 6'h00;
      fwd <= 1'b0;
      wait_on(0, 16'h0000);
      $display("test preset speeds done");
      // standard mode: both runs only stop, no alarm
      wr_reg(6'h00, 16'h0030);
      fwd <= 1'b1;
      wait_on(0, 16'h0bb8);
      rev <= 1'b1;
      wait_on(0, 16'h0000);
      chk(alarm, 32'h0);
      fwd <= 1'b0;
      rev <= 1'b0;
      // three-step: accel, hold, then back to the run level
      wr_reg(6'h00, 16'h0032);
      aux <= 6'h04;
      fwd <= 1'b1;
      wait_on(0, 16'h0bb8);
      aux <= 6'h08;
      repeat (100) @(posedge core_clk);
      chk(freq, 32'h0bb8);
      aux <= 6'h00;
      wait_on(0, 16'h0258);
      $display("test standard and three-step done");
      // analog: half of the span above the lower limit
      ana <= 12'h800;
      wr_reg(6'h00, 16'h0036);
      wait_on(0, 16'h0708);
      chk(dir, 32'h0);
      fwd <= 1'b0;
      wait_on(0, 16'h0000);
      ana <= 12'hc00;
      wr_reg(6'h00, 16'h0037);
      fwd <= 1'b1;
      wait_on(0, 16'h0708);
      chk(dir, 32'h1);
      fwd <= 1'b0;
      wait_on(0, 16'h0000);
      $display("test analog modes done");
      complete_run();
   end
endmodule : tb
